// File: opc_cfg.svh
// Register offsets, field positions, reset values and scaling for the output path block
`ifndef OPC_CFG_SVH
`define OPC_CFG_SVH

// Register offsets in the codec register space
`define OPC_BYPASS_GAIN_CH1_OFS 16'h002C
`define OPC_BIAS_CTRL_OFS 16'h002D
`define OPC_CONV_CTRL_OFS 16'h002E
`define OPC_CONV0_ATT_OFS 16'h002F
`define OPC_CONV1_ATT_OFS 16'h0030
`define OPC_PIN_MUTES_OFS 16'h0031

// Reset values
`define OPC_BYPASS_GAIN_CH1_RST 8'h00
`define OPC_BIAS_CTRL_RST 8'h00
`define OPC_CONV_CTRL_RST 8'h18
`define OPC_CONV0_ATT_RST 8'h00
`define OPC_CONV1_ATT_RST 8'h00
`define OPC_PIN_MUTES_RST 8'h0F

// Writable bit masks; all other bits are reserved
`define OPC_BIAS_CTRL_MASK 8'h33
`define OPC_CONV_CTRL_MASK 8'h3B
`define OPC_PIN_MUTES_MASK 8'h0F

// Bias control field positions
`define OPC_BIAS1_ON_BIT 5
`define OPC_BIAS0_ON_BIT 4
`define OPC_BIAS1_LVL_BIT 1
`define OPC_BIAS0_LVL_BIT 0

// Converter control field positions
`define OPC_CONV_INVERT_BIT 5
`define OPC_CONV1_SILENCE_BIT 4
`define OPC_CONV0_SILENCE_BIT 3
`define OPC_CONV1_ON_BIT 1
`define OPC_CONV0_ON_BIT 0

// Pin mute field positions (low bit of each field is the positive pin)
`define OPC_RIGHT_MUTE_LSB 2
`define OPC_LEFT_MUTE_LSB 0

// Attenuation step in thousandths of a dB, and in eighths of a dB
`define OPC_STEP_MILLIDB 375
`define OPC_STEP_EIGHTHS_DB 3

`endif

// File: opc_pkg.sv
// Types shared by the output path control block
`default_nettype none
package opc_pkg;
   typedef logic [7:0] opc_byte_type;
   // Attenuation in eighths of a dB, up to 255 steps of 3
   typedef logic [9:0] opc_eighths_type;
   typedef enum logic {
      opc_bias_0p90_type_val,
      opc_bias_0p65_type_val
   } opc_bias_level_type;
endpackage : opc_pkg
`default_nettype wire

// File: opc_chan_if.sv
// Settings and results passed between the register bank and one output channel
`default_nettype none
interface opc_chan_if;
   opc_pkg::opc_byte_type volume;
   opc_pkg::opc_byte_type bypass_gain;
   logic bypass_active;
   logic conv_on;
   logic conv_silence;
   logic [1:0] pin_field;
   opc_pkg::opc_byte_type eff_step;
   opc_pkg::opc_eighths_type eff_eighths;
   logic drive;
   logic pos_mute;
   logic neg_mute;

   modport regs (
      output volume, bypass_gain, bypass_active, conv_on, conv_silence, pin_field,
      input eff_step, eff_eighths, drive, pos_mute, neg_mute
   );
   modport chan (
      input volume, bypass_gain, bypass_active, conv_on, conv_silence, pin_field,
      output eff_step, eff_eighths, drive, pos_mute, neg_mute
   );
endinterface : opc_chan_if
`default_nettype wire

// File: opc_chan.sv
// One output channel: picks its gain, scales it to dB and decodes pin mutes
`default_nettype none
`include "opc_cfg.svh"
module opc_chan (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Channel settings and results
   opc_chan_if.chan ch
);
   opc_pkg::opc_byte_type step_d;
   opc_pkg::opc_eighths_type eighths_d;

   assign step_d = ch.bypass_active ? ch.bypass_gain : ch.volume;
   assign eighths_d = 10'(step_d) * 10'(`OPC_STEP_EIGHTHS_DB);

   // Registered attenuation; zero code is 0 dB so reset matches the registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ch.eff_step <= 8'h00;
         ch.eff_eighths <= 10'h000;
      end else begin
         ch.eff_step <= step_d;
         ch.eff_eighths <= eighths_d;
      end
   end

   // Converter drives only when enabled and not silenced
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ch.drive <= 1'b0;
      end else begin
         ch.drive <= ch.conv_on & ~ch.conv_silence;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ch.pos_mute <= 1'b1;
         ch.neg_mute <= 1'b1;
      end else begin
         ch.pos_mute <= ch.pin_field[0];
         ch.neg_mute <= ch.pin_field[1];
      end
   end
endmodule : opc_chan
`default_nettype wire

// File: opc_regs.sv
// Output path control register bank with bias, converter and pin mute controls
`default_nettype none
`include "opc_cfg.svh"
module opc_regs (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Register access port
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_ack_out,
   // Bypass mode pin from the processor side
   input wire logic bypass_active_in,
   // Bias outputs
   output logic bias_out_1_on_out,
   output logic bias_out_0_on_out,
   output logic bias1_level_sel_out,
   output logic bias0_level_sel_out,
   // Converter controls
   output logic converter_invert_out,
   output logic conv1_on_out,
   output logic conv0_on_out,
   output logic conv1_silence_out,
   output logic conv0_silence_out,
   output logic conv1_drive_out,
   output logic conv0_drive_out,
   // Effective attenuation, in steps and in eighths of a dB
   output logic [7:0] conv0_attenuation_out,
   output logic [7:0] conv1_attenuation_out,
   output logic [9:0] conv0_att_eighths_out,
   output logic [9:0] conv1_att_eighths_out,
   // Output pin mutes
   output logic left_positive_pin_mute_out,
   output logic left_negative_pin_mute_out,
   output logic right_positive_pin_mute_out,
   output logic right_negative_pin_mute_out
);
   logic rst_meta_q;
   logic rst_sync_q;
   logic byp_meta_q;
   logic byp_sync_q;
   opc_pkg::opc_byte_type bypass_gain_ch1_q;
   opc_pkg::opc_byte_type bias_ctrl_q;
   opc_pkg::opc_byte_type conv_ctrl_q;
   opc_pkg::opc_byte_type conv0_attenuation_q;
   opc_pkg::opc_byte_type conv1_attenuation_q;
   opc_pkg::opc_byte_type pin_mutes_q;
   opc_pkg::opc_byte_type rdata_d;
   opc_pkg::opc_byte_type rdata_q;
   logic ack_q;
   opc_pkg::opc_bias_level_type bias1_level;
   opc_pkg::opc_bias_level_type bias0_level;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Bypass pin comes from another domain, so synchronise it
   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         byp_meta_q <= 1'b0;
         byp_sync_q <= 1'b0;
      end else begin
         byp_meta_q <= bypass_active_in;
         byp_sync_q <= byp_meta_q;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         bypass_gain_ch1_q <= `OPC_BYPASS_GAIN_CH1_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_BYPASS_GAIN_CH1_OFS) begin
         bypass_gain_ch1_q <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         bias_ctrl_q <= `OPC_BIAS_CTRL_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_BIAS_CTRL_OFS) begin
         bias_ctrl_q <= reg_wdata_in & `OPC_BIAS_CTRL_MASK;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         conv_ctrl_q <= `OPC_CONV_CTRL_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_CONV_CTRL_OFS) begin
         // bits 7, 6 and 2 held zero
         conv_ctrl_q <= reg_wdata_in & `OPC_CONV_CTRL_MASK;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         conv0_attenuation_q <= `OPC_CONV0_ATT_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_CONV0_ATT_OFS) begin
         conv0_attenuation_q <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         conv1_attenuation_q <= `OPC_CONV1_ATT_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_CONV1_ATT_OFS) begin
         conv1_attenuation_q <= reg_wdata_in;
      end
   end

   // pin mute fields, both reset muted
   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pin_mutes_q <= `OPC_PIN_MUTES_RST;
      end else if (reg_wr_in && reg_addr_in == `OPC_PIN_MUTES_OFS) begin
         pin_mutes_q <= reg_wdata_in & `OPC_PIN_MUTES_MASK;
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rdata_d = 8'h00;
      unique case (reg_addr_in)
         `OPC_BYPASS_GAIN_CH1_OFS: rdata_d = bypass_gain_ch1_q;
         `OPC_BIAS_CTRL_OFS: rdata_d = bias_ctrl_q;
         `OPC_CONV_CTRL_OFS: rdata_d = conv_ctrl_q;
         `OPC_CONV0_ATT_OFS: rdata_d = conv0_attenuation_q;
         `OPC_CONV1_ATT_OFS: rdata_d = conv1_attenuation_q;
         `OPC_PIN_MUTES_OFS: rdata_d = pin_mutes_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data held until the next read; ack pulses for any access
   always_ff @(posedge mclk_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= 8'h00;
         ack_q <= 1'b0;
      end else begin
         ack_q <= reg_rd_in | reg_wr_in;
         if (reg_rd_in) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign reg_rdata_out = rdata_q;
   assign reg_ack_out = ack_q;

   // bias level decode, 0 is 0.9 and 1 is 0.65 of supply
   assign bias1_level = opc_pkg::opc_bias_level_type'(bias_ctrl_q[`OPC_BIAS1_LVL_BIT]);
   assign bias0_level = opc_pkg::opc_bias_level_type'(bias_ctrl_q[`OPC_BIAS0_LVL_BIT]);
   assign bias1_level_sel_out = (bias1_level == opc_pkg::opc_bias_0p65_type_val);
   assign bias0_level_sel_out = (bias0_level == opc_pkg::opc_bias_0p65_type_val);

   assign bias_out_1_on_out = bias_ctrl_q[`OPC_BIAS1_ON_BIT];
   assign bias_out_0_on_out = bias_ctrl_q[`OPC_BIAS0_ON_BIT];

   assign converter_invert_out = conv_ctrl_q[`OPC_CONV_INVERT_BIT];
   assign conv1_on_out = conv_ctrl_q[`OPC_CONV1_ON_BIT];
   assign conv0_on_out = conv_ctrl_q[`OPC_CONV0_ON_BIT];
   assign conv1_silence_out = conv_ctrl_q[`OPC_CONV1_SILENCE_BIT];
   assign conv0_silence_out = conv_ctrl_q[`OPC_CONV0_SILENCE_BIT];

   // Per-channel processing; channel 0 is left, channel 1 is right
   opc_chan_if ch_if[2] ();

   // Channel 0 has no bypass gain here, so it keeps its own volume
   assign ch_if[0].volume = conv0_attenuation_q;
   assign ch_if[0].bypass_gain = conv0_attenuation_q;
   assign ch_if[0].bypass_active = 1'b0;
   assign ch_if[0].conv_on = conv_ctrl_q[`OPC_CONV0_ON_BIT];
   assign ch_if[0].conv_silence = conv_ctrl_q[`OPC_CONV0_SILENCE_BIT];
   assign ch_if[0].pin_field = pin_mutes_q[`OPC_LEFT_MUTE_LSB +: 2];

   assign ch_if[1].volume = conv1_attenuation_q;
   assign ch_if[1].bypass_gain = bypass_gain_ch1_q;
   assign ch_if[1].bypass_active = byp_sync_q;
   assign ch_if[1].conv_on = conv_ctrl_q[`OPC_CONV1_ON_BIT];
   assign ch_if[1].conv_silence = conv_ctrl_q[`OPC_CONV1_SILENCE_BIT];
   assign ch_if[1].pin_field = pin_mutes_q[`OPC_RIGHT_MUTE_LSB +: 2];

   for (genvar g = 0; g < 2; g++) begin : g_chan
      opc_chan u_chan (
         .clk_in(mclk_in),
         .rst_n_in(rst_sync_q),
         .ch(ch_if[g])
      );
   end

   assign conv0_attenuation_out = ch_if[0].eff_step;
   assign conv1_attenuation_out = ch_if[1].eff_step;
   assign conv0_att_eighths_out = ch_if[0].eff_eighths;
   assign conv1_att_eighths_out = ch_if[1].eff_eighths;
   assign conv0_drive_out = ch_if[0].drive;
   assign conv1_drive_out = ch_if[1].drive;

   // each pin mute driven on its own
   assign left_positive_pin_mute_out = ch_if[0].pos_mute;
   assign left_negative_pin_mute_out = ch_if[0].neg_mute;
   assign right_positive_pin_mute_out = ch_if[1].pos_mute;
   assign right_negative_pin_mute_out = ch_if[1].neg_mute;
endmodule : opc_regs
`default_nettype wire

// File: opc_regs_assertions.sv
// Concurrent checks on the output path control register bank ports
`default_nettype none
module opc_regs_assertions (
   // Clock, reset and register port
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_ack_out,
   // Watched outputs
   input wire logic bias_out_1_on_out,
   input wire logic bias_out_0_on_out,
   input wire logic bias1_level_sel_out,
   input wire logic bias0_level_sel_out,
   input wire logic converter_invert_out,
   input wire logic conv0_on_out,
   input wire logic conv0_silence_out,
   input wire logic conv0_drive_out,
   input wire logic [7:0] conv0_attenuation_out,
   input wire logic [7:0] conv1_attenuation_out,
   input wire logic [9:0] conv0_att_eighths_out,
   input wire logic [9:0] conv1_att_eighths_out,
   input wire logic left_positive_pin_mute_out,
   input wire logic left_negative_pin_mute_out,
   input wire logic right_positive_pin_mute_out,
   input wire logic right_negative_pin_mute_out
);
   logic w2d, w2e, w2f, w31, rd_hole;
   // Address decodes for the writes and the unmapped reads being watched
   assign w2d = reg_wr_in && reg_addr_in == 16'h002D;
   assign w2e = reg_wr_in && reg_addr_in == 16'h002E;
   assign w2f = reg_wr_in && reg_addr_in == 16'h002F;
   assign w31 = reg_wr_in && reg_addr_in == 16'h0031;
   assign rd_hole = reg_rd_in && (reg_addr_in < 16'h002C || reg_addr_in > 16'h0031);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   a_ack_after_req: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
      else $error("ack missing after access");
   a_bias_fields: assert property (w2d |=>
      {bias_out_1_on_out, bias_out_0_on_out, bias1_level_sel_out, bias0_level_sel_out}
      == {$past(reg_wdata_in[5:4]), $past(reg_wdata_in[1:0])}) else $error("bias fields");
   a_conv_fields: assert property (w2e |=> {converter_invert_out, conv0_silence_out,
      conv0_on_out} == {$past(reg_wdata_in[5]), $past(reg_wdata_in[3]), $past(reg_wdata_in[0])})
      else $error("converter control fields");
   a_drive_follows: assert property (conv0_drive_out ==
      ($past(conv0_on_out) && !$past(conv0_silence_out))) else $error("drive wrong");
   a_att0_write: assert property (w2f |=> ##1
      conv0_attenuation_out == $past(reg_wdata_in, 2)) else $error("attenuation 0 write");
   a_att0_scale: assert property (
      conv0_att_eighths_out == 10'(conv0_attenuation_out) * 10'd3) else $error("scale 0");
   a_att1_scale: assert property (
      conv1_att_eighths_out == 10'(conv1_attenuation_out) * 10'd3) else $error("scale 1");
   a_right_mutes: assert property (w31 |=> ##1
      {right_negative_pin_mute_out, right_positive_pin_mute_out} == $past(reg_wdata_in[3:2], 2))
      else $error("right pin mutes");
   a_left_mutes: assert property (w31 |=> ##1
      {left_negative_pin_mute_out, left_positive_pin_mute_out} == $past(reg_wdata_in[1:0], 2))
      else $error("left pin mutes");
   a_hole_reads_zero: assert property (rd_hole |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   // Main scenarios reached
   c_one_pin: cover property (w31 && reg_wdata_in[1:0] == 2'b01);
   c_drive_on: cover property (conv0_drive_out);
   c_hole_read: cover property (rd_hole);
endmodule : opc_regs_assertions
`default_nettype wire

// File: opc_regs_bench.sv
// Self-checking bench for the output path control register bank
`default_nettype none
module opc_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [15:0] reg_addr_in = 16'h0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic bypass_active_in = 1'b0;
   logic [7:0] rdata, att0, att1, v, qe;
   logic [9:0] e0, e1;
   logic ack, b1, b0, l1, l0, inv, on1, on0, s1, s0, d1, d0, lp, ln, rp, rn;
   bit qc;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 36;
   logic [7:0] expq[$];
   bit chkq[$];
   logic [7:0] msk[6] = '{8'hFF, 8'h33, 8'h3B, 8'hFF, 8'hFF, 8'h0F};
   logic [7:0] rstv[6] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h0F};
   logic [7:0] codes[4] = '{8'h00, 8'h01, 8'hFF, 8'h55};
   opc_regs DUT (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
      .reg_rdata_out(rdata), .reg_ack_out(ack), .bypass_active_in, .bias_out_1_on_out(b1),
      .bias_out_0_on_out(b0), .bias1_level_sel_out(l1), .bias0_level_sel_out(l0),
      .converter_invert_out(inv), .conv1_on_out(on1), .conv0_on_out(on0),
      .conv1_silence_out(s1), .conv0_silence_out(s0), .conv1_drive_out(d1),
      .conv0_drive_out(d0), .conv0_attenuation_out(att0), .conv1_attenuation_out(att1),
      .conv0_att_eighths_out(e0), .conv1_att_eighths_out(e1),
      .left_positive_pin_mute_out(lp), .left_negative_pin_mute_out(ln),
      .right_positive_pin_mute_out(rp), .right_negative_pin_mute_out(rn));
   // Free-running 200 MHz clock
   always #2.5 mclk_in = ~mclk_in;
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // One strobe cycle; the note is queued before the edge that takes it
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] e);
      @(posedge mclk_in);
      #1;
      reg_wr_in = w;
      reg_rd_in = !w;
      reg_addr_in = a;
      reg_wdata_in = d;
      expq.push_back(e);
      chkq.push_back(!w);
      @(posedge mclk_in);
      #1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
   endtask : acc
   // Each ack retires the oldest note; only reads carry data worth comparing
   always @(posedge mclk_in) begin
      if (ack === 1'b1) begin
         if (expq.size() == 0) begin
            chk("stray ack", 10'h000, 10'h001);
         end else begin
            qe = expq.pop_front();
            qc = chkq.pop_front();
            if (qc) begin
               chk("read data", 10'(qe), 10'(rdata));
            end
         end
      end
   end
   // Hang guard, far above the few hundred cycles the sequence needs
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge mclk_in);
      #1;
      arst_n_in = 1'b1;
      repeat (3) @(posedge mclk_in);
      // Sample off the edge so the reset values are settled
      #1;
      chk("pins at reset", 10'({lp, ln, rp, rn}), 10'h00F);
      chk("conv at reset", 10'({s1, s0, on1, on0, inv}), 10'h018);
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, 16'h002C + 16'(i), 8'h00, rstv[i]);
      end
      repeat (4) begin
         for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            acc(1'b1, 16'h002C + 16'(i), v, 8'h00);
            acc(1'b0, 16'h002C + 16'(i), 8'h00, v & msk[i]);
         end
      end
      foreach (codes[k]) begin
         acc(1'b1, 16'h002F, codes[k], 8'h00);
         // Attenuation flop lags the register by one edge
         @(posedge mclk_in);
         #1;
         chk("att0", 10'(att0), 10'(codes[k]));
         chk("att0 eighths", e0, 10'(codes[k]) * 10'd3);
      end
      repeat (6) begin
         v = 8'($random(seed));
         acc(1'b1, 16'h002E, v, 8'h00);
         // Drive flop lags the register by one edge
         @(posedge mclk_in);
         #1;
         chk("conv flags", 10'({s1, s0, on1, on0}), 10'({v[4], v[3], v[1], v[0]}));
         chk("drive", 10'({d1, d0}), 10'({v[1] & ~v[4], v[0] & ~v[3]}));
         chk("invert", 10'(inv), 10'(v[5]));
      end
      for (int m = 0; m < 16; m++) begin
         acc(1'b1, 16'h0031, 8'(m), 8'h00);
         // Pin mute flops lag the register by one edge
         @(posedge mclk_in);
         #1;
         chk("pins", 10'({rn, rp, ln, lp}), 10'(m));
      end
      acc(1'b1, 16'h0032, 8'hFF, 8'h00);
      acc(1'b0, 16'h0032, 8'h00, 8'h00);
      acc(1'b0, 16'h002B, 8'h00, 8'h00);
      acc(1'b0, 16'h0031, 8'h00, 8'h0F);
      acc(1'b1, 16'h002C, 8'h40, 8'h00);
      acc(1'b1, 16'h0030, 8'h20, 8'h00);
      @(posedge mclk_in);
      #1;
      chk("att1", 10'(att1), 10'h020);
      bypass_active_in = 1'b1;
      repeat (4) @(posedge mclk_in);
      #1;
      chk("att1 bypass", 10'(att1), 10'h040);
      chk("att1 eighths", e1, 10'd192);
      bypass_active_in = 1'b0;
      repeat (4) @(posedge mclk_in);
      #1;
      chk("att1 normal", 10'(att1), 10'h020);
      repeat (3) @(posedge mclk_in);
      wrap_up();
   end
endmodule : opc_regs_bench
bind opc_regs opc_regs_assertions chk_u (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wr_in,
   .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_ack_out, .bias_out_1_on_out,
   .bias_out_0_on_out, .bias1_level_sel_out, .bias0_level_sel_out, .converter_invert_out,
   .conv0_on_out, .conv0_silence_out, .conv0_drive_out, .conv0_attenuation_out,
   .conv1_attenuation_out, .conv0_att_eighths_out, .conv1_att_eighths_out,
   .left_positive_pin_mute_out, .left_negative_pin_mute_out, .right_positive_pin_mute_out,
   .right_negative_pin_mute_out);
`default_nettype wire
